// ### pfb_board_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - eight-bit page register picks one of 256 pages
// - page latched on rising edge of select-or-write
// - reset clears page register to page zero
// - page port read returns current page value
// - two top page bits pick one module
// - module decode enabled only by window hit
// - eight-bit host: upper lane routed to lower
// - width sense low on 16-bit, pulled high otherwise
// - width sense readable as presence port MSB
// - width sense muxes high-byte qualifier source
// - low strobe on memory write to even address
// - high strobe on high-enable write if 16-bit, on odd write if 8-bit
// - eight-bit host gets high byte on low lane
// - eight lane selects, even low, odd high
// - bank selection per width and address bit
// - inactive board never decodes memory
// - jumper sets active state at reset
// - ports at switch base, address bits 3-10
// - decode only while address enable low
// - shared port bit turns programming voltage on/off
module pfb_board_ctrl (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic                          aen,
    input  wire logic [pfb_pkg::ADDR_W-1:0]    addr,
    input  wire logic                          io_rd_n,
    input  wire logic                          io_wr_n,
    input  wire logic                          buffered_memory_write_n,
    input  wire logic                          buffered_high_byte_enable_n,
    input  wire logic                          bus_width_sense,
    input  wire logic                          activate_jumper_n,
    input  wire logic [pfb_pkg::IOBASE_W-1:0]  io_base_switch,
    input  wire logic [pfb_pkg::WIN_W-1:0]     window_switch,
    input  wire logic [pfb_pkg::PD_W-1:0]      presence_detect,
    input  wire logic [pfb_pkg::DATA_W-1:0]    io_data_in,
    output logic      [pfb_pkg::DATA_W-1:0]    io_data_out,
    output logic                               io_data_oe,
    output logic      [pfb_pkg::PAGE_W-1:0]    flash_page_select,
    output logic                               mem_window_hit,
    output logic      [pfb_pkg::LANE_W-1:0]    lane_transceiver_selects_n,
    output logic                               low_byte_write_strobe_n,
    output logic                               high_byte_write_strobe_n,
    output logic                               upper_to_lower_route,
    output logic                               prog_voltage_enable,
    output logic                               board_activate_n
);
    import pfb_pkg::*;

    // every host pin is asynchronous to clk; two stages before use
    logic [SYNC_W-1:0]   s1_q;
    logic [SYNC_W-1:0]   s2_q;
    logic [SYNC_W-1:0]   s_in;
    logic                aen_s;
    logic                rd_n_s;
    logic                wr_n_s;
    logic                memw_n_s;
    logic                bhe_n_s;
    logic                width_s;
    logic                jmp_n_s;
    logic [ADDR_W-1:0]   a_s;
    logic [DATA_W-1:0]   d_s;
    logic [PD_W-1:0]     pd_s;
    logic [IOBASE_W-1:0] base_s;
    logic [WIN_W-1:0]    win_s;

    assign s_in = {aen, io_rd_n, io_wr_n, buffered_memory_write_n,
                   buffered_high_byte_enable_n, bus_width_sense,
                   activate_jumper_n, addr, io_data_in, presence_detect,
                   io_base_switch, window_switch};
    assign {aen_s, rd_n_s, wr_n_s, memw_n_s, bhe_n_s, width_s, jmp_n_s,
            a_s, d_s, pd_s, base_s, win_s} = s2_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= SYNC_RST;
            s2_q <= SYNC_RST;
        end else begin
            s1_q <= s_in;
            s2_q <= s1_q;
        end
    end

    // registered state
    logic [PAGE_W-1:0]   page_q, page_d;
    logic [DATA_W-1:0]   hold_q, hold_d;
    logic                pwclk_q, pwclk_d;
    logic                swclk_q, swclk_d;
    logic                prog_q, prog_d;
    logic                act_n_q, act_n_d;
    logic [1:0]          boot_q, boot_d;
    logic [DATA_W-1:0]   dout_q, dout_d;
    logic                oe_q, oe_d;
    logic                hit_q;
    logic [LANE_W-1:0]   sel_q, sel_d;
    logic                lwr_n_q, lwr_n_d;
    logic                hwr_n_q, hwr_n_d;
    logic                route_q, route_d;

    // decode terms
    logic                io_hit;
    logic [2:0]          port;
    logic                page_sel;
    logic                share_sel;
    logic                rd_page;
    logic                rd_any;
    logic                rd_pd;
    logic                pw_rise;
    logic                sw_rise;
    logic                win_hit;
    logic                hi_qual;
    logic                lo_bank;
    logic                hi_bank;

    assign io_hit    = !aen_s && (a_s[IO_CMP_HI:IO_CMP_LO] == base_s);
    assign port      = a_s[PORT_HI:PORT_LO];
    assign page_sel  = io_hit && (port == PORT_PAGE);
    assign share_sel = io_hit && (port == PORT_SHARED);
    assign rd_page   = page_sel && !rd_n_s;
    assign rd_pd     = io_hit && (port == PORT_PRESENCE) && !rd_n_s;
    assign rd_any    = io_hit && !rd_n_s && (port >= PORT_WINDOW);
    // strobes are high while idle; low-to-high is the capture edge
    assign pw_rise   = !pwclk_q && pwclk_d;
    assign sw_rise   = !swclk_q && swclk_d;

    // inactive board or dma cycle blocks all memory decode
    assign win_hit = !aen_s && !act_n_q
                     && (a_s[WIN_HI:WIN_LO] == win_s);
    // width_s high means an 8-bit host left the sense line pulled up
    assign hi_qual = width_s ? a_s[0] : !bhe_n_s;
    assign lo_bank = win_hit && !(width_s && a_s[0]);
    assign hi_bank = win_hit && (!width_s || a_s[0]);

    always_comb begin
        pwclk_d = !page_sel || wr_n_s;
        swclk_d = !share_sel || wr_n_s;
        // data held from the last cycle the strobe was low
        hold_d  = (!pwclk_d || !swclk_d) ? d_s : hold_q;
        page_d  = pw_rise ? hold_q : page_q;
        prog_d  = sw_rise ? hold_q[PROG_BIT] : prog_q;
        act_n_d = sw_rise ? hold_q[ACT_BIT] : act_n_q;
        boot_d  = (boot_q == BOOT_DONE) ? boot_q : boot_q + 2'h1;
        if (boot_q == BOOT_LOAD) begin
            act_n_d = jmp_n_s;
        end
        oe_d   = rd_any;
        dout_d = dout_q;
        if (rd_any) begin
            unique case (port)
                PORT_PAGE:     dout_d = page_q;
                PORT_PRESENCE: dout_d = {width_s, pd_s};
                PORT_SHARED:   dout_d = {6'h00, act_n_q, prog_q};
                default:       dout_d = {4'h0, win_s};
            endcase
        end
        lwr_n_d = !(win_hit && !memw_n_s && !a_s[0]);
        hwr_n_d = !(win_hit && !memw_n_s && hi_qual);
        route_d = width_s && win_hit && a_s[0];
    end

    // one low and one high lane select per module
    genvar gm;
    generate
        for (gm = 0; gm < NUM_MODULES; gm++) begin : g_module
            logic mod_on;
            assign mod_on = (page_q[BANK_HI:BANK_LO] == 2'(gm));
            assign sel_d[2*gm]   = !(lo_bank && mod_on);
            assign sel_d[2*gm+1] = !(hi_bank && mod_on);
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            page_q  <= PAGE_RST;
            hold_q  <= DOUT_RST;
            pwclk_q <= 1'b1;
            swclk_q <= 1'b1;
            prog_q  <= 1'b0;
            act_n_q <= 1'b1;
            boot_q  <= 2'h0;
            dout_q  <= DOUT_RST;
            oe_q    <= 1'b0;
            hit_q   <= 1'b0;
            sel_q   <= SEL_RST;
            lwr_n_q <= 1'b1;
            hwr_n_q <= 1'b1;
            route_q <= 1'b0;
        end else begin
            page_q  <= page_d;
            hold_q  <= hold_d;
            pwclk_q <= pwclk_d;
            swclk_q <= swclk_d;
            prog_q  <= prog_d;
            act_n_q <= act_n_d;
            boot_q  <= boot_d;
            dout_q  <= dout_d;
            oe_q    <= oe_d;
            hit_q   <= win_hit;
            sel_q   <= sel_d;
            lwr_n_q <= lwr_n_d;
            hwr_n_q <= hwr_n_d;
            route_q <= route_d;
        end
    end

    assign io_data_out                = dout_q;
    assign io_data_oe                 = oe_q;
    assign flash_page_select          = page_q;
    assign mem_window_hit             = hit_q;
    assign lane_transceiver_selects_n = sel_q;
    assign low_byte_write_strobe_n    = lwr_n_q;
    assign high_byte_write_strobe_n   = hwr_n_q;
    assign upper_to_lower_route       = route_q;
    assign prog_voltage_enable        = prog_q;
    assign board_activate_n           = act_n_q;

    a_page_capture: assert property (@(posedge clk) disable iff (!reset_n)
        pw_rise |=> flash_page_select == $past(hold_q))
        else $error("page not captured on strobe edge");

    a_page_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !pw_rise |=> $stable(flash_page_select))
        else $error("page changed without page strobe");

    a_page_reset: assert property (@(posedge clk) disable iff (!reset_n)
        boot_q == 2'h0 |-> flash_page_select == 8'h00)
        else $error("page not zero after reset");

    a_page_read: assert property (@(posedge clk) disable iff (!reset_n)
        rd_page |=> io_data_oe && io_data_out == $past(page_q))
        else $error("page read returned wrong value");

    a_oe_release: assert property (@(posedge clk) disable iff (!reset_n)
        !rd_any |=> !io_data_oe)
        else $error("data driver left on");

    a_no_hit_off: assert property (@(posedge clk) disable iff (!reset_n)
        !win_hit |=> lane_transceiver_selects_n == 8'hff)
        else $error("lane select without window hit");

    a_wide_banks: assert property (@(posedge clk) disable iff (!reset_n)
        win_hit && !width_s |=> lane_transceiver_selects_n ==
        ~(8'h03 << {$past(page_q[BANK_HI:BANK_LO]), 1'b0}))
        else $error("wrong module lanes on 16-bit host");

    a_low_strobe: assert property (@(posedge clk) disable iff (!reset_n)
        win_hit && !memw_n_s && !a_s[0]
        |=> !low_byte_write_strobe_n)
        else $error("low strobe missing on even write");

    a_high_narrow: assert property (@(posedge clk) disable iff (!reset_n)
        width_s && win_hit && !memw_n_s
        |=> high_byte_write_strobe_n == !$past(a_s[0]))
        else $error("high strobe wrong on 8-bit host");

    a_route_narrow: assert property (@(posedge clk) disable iff (!reset_n)
        upper_to_lower_route |-> $past(width_s) && mem_window_hit)
        else $error("lane route on 16-bit host");

    a_width_read: assert property (@(posedge clk) disable iff (!reset_n)
        rd_pd |=> io_data_out[7] == $past(width_s))
        else $error("width sense not in presence msb");

    a_prog_write: assert property (@(posedge clk) disable iff (!reset_n)
        sw_rise |=> prog_voltage_enable == $past(hold_q[PROG_BIT]))
        else $error("programming voltage bit not written");

    a_inactive_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        board_activate_n && $past(board_activate_n)
        |-> !mem_window_hit)
        else $error("inactive board decoded memory");

    a_aen_block: assert property (@(posedge clk) disable iff (!reset_n)
        aen_s |=> !mem_window_hit && lane_transceiver_selects_n == 8'hff)
        else $error("decode during dma cycle");

    a_boot_strap: assert property (@(posedge clk) disable iff (!reset_n)
        boot_q == 2'h2 |=> board_activate_n == $past(jmp_n_s))
        else $error("jumper not loaded after reset");

    a_port_base: assert property (@(posedge clk) disable iff (!reset_n)
        pw_rise |-> $past(io_hit))
        else $error("page write outside board base");

endmodule // pfb_board_ctrl
`default_nettype wire

// ### pfb_pkg.sv
package pfb_pkg;
    localparam int ADDR_W      = 20;
    localparam int DATA_W      = 8;
    localparam int PAGE_W      = 8;
    localparam int NUM_PAGES   = 256;
    localparam int PAGE_KBYTES = 64;
    localparam int NUM_MODULES = 4;
    localparam int LANE_W      = 8;
    localparam int PD_W        = 7;
    localparam int IOBASE_W    = 8;
    localparam int WIN_W       = 4;
    localparam int IO_CMP_LO   = 3;
    localparam int IO_CMP_HI   = 10;
    localparam int WIN_LO      = 16;
    localparam int WIN_HI      = 19;
    localparam int BANK_LO     = 6;
    localparam int BANK_HI     = 7;
    localparam int PORT_LO     = 0;
    localparam int PORT_HI     = 2;
    localparam logic [2:0] PORT_WINDOW   = 3'h4;
    localparam logic [2:0] PORT_PRESENCE = 3'h5;
    localparam logic [2:0] PORT_SHARED   = 3'h6;
    localparam logic [2:0] PORT_PAGE     = 3'h7;
    localparam int PROG_BIT    = 0;
    localparam int ACT_BIT     = 1;
    localparam logic [7:0] PAGE_RST  = 8'h00;
    localparam logic [7:0] DOUT_RST  = 8'h00;
    localparam logic [7:0] SEL_RST   = 8'hff;
    localparam int SYNC_W      = 54;
    localparam logic [53:0] SYNC_RST = {7'h7f, 47'h0};
    localparam logic [1:0] BOOT_LOAD = 2'h2;
    localparam logic [1:0] BOOT_DONE = 2'h3;
endpackage

// ### pfb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pfb_host_model (
    input  wire logic         clk,
    input  wire logic [7:0]   data_out,
    input  wire logic         data_oe,
    output logic              aen,
    output logic [19:0]       addr,
    output logic              io_rd_n,
    output logic              io_wr_n,
    output logic              memw_n,
    output logic              bhe_n,
    output logic              width_8bit,
    output logic [7:0]        data_in
);
    logic [7:0] last_q = 8'h00;
    logic [7:0] bus;
    // undriven bus must not echo the last byte, so show its inverse
    assign bus = data_oe ? data_out : ~last_q;
    always @(posedge clk) if (data_oe) last_q <= data_out;
    initial begin
        aen = 1'b0;
        addr = 20'h00000;
        io_rd_n = 1'b1;
        io_wr_n = 1'b1;
        memw_n = 1'b1;
        bhe_n = 1'b1;
        width_8bit = 1'b1;
        data_in = 8'h00;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // strobes held four cycles, above the two-cycle sampling minimum
    task automatic io_wr(input logic [19:0] a, input logic [7:0] d);
        cyc(1);
        addr = a;
        data_in = d;
        io_wr_n = 1'b0;
        cyc(4);
        io_wr_n = 1'b1;
        cyc(5);
        data_in = ~d;
    endtask
    task automatic io_rd(input logic [19:0] a, output logic [7:0] d);
        cyc(1);
        addr = a;
        io_rd_n = 1'b0;
        cyc(4);
        d = bus;
        io_rd_n = 1'b1;
        cyc(5);
    endtask
    task automatic mem(input logic [19:0] a, input logic w_n, b_n);
        cyc(1);
        addr = a;
        memw_n = w_n;
        bhe_n = b_n;
        cyc(4);
    endtask
    // read first so only the activation bit changes
    task automatic activate(input logic [19:0] a, input logic act_n);
        logic [7:0] v;
        io_rd(a, v);
        io_wr(a, (v & 8'hfd) | {6'h0, act_n, 1'b0});
    endtask
endmodule // pfb_host_model
`default_nettype wire

// ### paged_flash_board_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module paged_flash_board_control_tb;
    import pfb_pkg::*;
    localparam logic [19:0] BASE = 20'h00308;
    localparam logic [3:0]  WIN  = 4'hd;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic aen, rd_n, wr_n, memw_n, bhe_n, width, oe, hit, wrl_n, wrh_n;
    logic route, prog, act_n;
    logic [19:0] addr;
    logic [7:0]  din, dout, page, sel_n, d;
    // strap and presence pins are driven so both levels get exercised
    logic        jmp_n = 1'b0;
    logic [6:0]  pd = 7'h35;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    pfb_board_ctrl dut (
        .clk(clk), .reset_n(reset_n), .aen(aen), .addr(addr),
        .io_rd_n(rd_n), .io_wr_n(wr_n), .buffered_memory_write_n(memw_n),
        .buffered_high_byte_enable_n(bhe_n), .bus_width_sense(width),
        .activate_jumper_n(jmp_n), .io_base_switch(8'h61),
        .window_switch(WIN), .presence_detect(pd), .io_data_in(din),
        .io_data_out(dout), .io_data_oe(oe), .flash_page_select(page),
        .mem_window_hit(hit), .lane_transceiver_selects_n(sel_n),
        .low_byte_write_strobe_n(wrl_n), .high_byte_write_strobe_n(wrh_n),
        .upper_to_lower_route(route), .prog_voltage_enable(prog),
        .board_activate_n(act_n));
    pfb_host_model host (.clk(clk), .data_out(dout), .data_oe(oe),
        .aen(aen), .addr(addr), .io_rd_n(rd_n), .io_wr_n(wr_n),
        .memw_n(memw_n), .bhe_n(bhe_n), .width_8bit(width), .data_in(din));
    always #20 clk = ~clk;
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic check(input string nm, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic t_reset();
        repeat (16) @(posedge clk);
        check("page", page, PAGE_RST);
        check("sel", sel_n, 8'hff);
        #2 reset_n = 1'b1;
        host.cyc(6);
        check("act", {7'h0, act_n}, 8'h00);
        check("prog", {7'h0, prog}, 8'h00);
    endtask
    task automatic t_page();
        logic [7:0] vals [4] = '{8'h5a, 8'hff, 8'h81, 8'h00};
        foreach (vals[i]) begin
            host.io_wr(BASE + 20'h7, vals[i]);
            check("page", page, vals[i]);
            host.io_rd(BASE + 20'h7, d);
            check("read", d, vals[i]);
            check("oe", {7'h0, oe}, 8'h00);
        end
        host.io_wr(BASE + 20'h7, 8'h3c);
        for (int p = 0; p < 6; p++) host.io_wr(BASE + p, 8'hc3);
        check("page", page, 8'h3c);
        host.io_wr(BASE + 20'h0f, 8'h11);
        check("page", page, 8'h3c);
        host.aen = 1'b1;
        host.io_wr(BASE + 20'h7, 8'h22);
        host.aen = 1'b0;
        check("page", page, 8'h3c);
    endtask
    task automatic t_ports();
        for (int w = 0; w < 2; w++) begin
            host.width_8bit = w[0];
            pd = w[0] ? 7'h4a : 7'h35;
            host.io_rd(BASE + 20'h5, d);
            check("presence", d, {w[0], pd});
        end
        host.io_rd(BASE + 20'h4, d);
        check("window", d, {4'h0, WIN});
        host.io_wr(BASE + 20'h6, 8'h01);
        check("prog", {7'h0, prog}, 8'h01);
        host.io_wr(BASE + 20'h6, 8'h00);
        check("prog", {7'h0, prog}, 8'h00);
    endtask
    task automatic t_mem();
        logic lo, hi;
        for (int b = 0; b < 4; b++) begin
            host.io_wr(BASE + 20'h7, {b[1:0], 6'h15});
            for (int k = 0; k < 16; k++) begin
                // low byte before high byte on the narrow host
                host.width_8bit = k[3];
                host.mem({WIN, 15'h2b3c, k[0]}, k[2], k[1]);
                lo = k[3] ? !k[0] : 1'b1;
                hi = k[3] ? k[0] : 1'b1;
                check("hit", {7'h0, hit}, 8'h01);
                check("sel", sel_n, ~({6'h0, hi, lo} << (2 * b)));
                check("wrl", {7'h0, wrl_n}, {7'h0, k[2] | k[0]});
                check("wrh", {7'h0, wrh_n},
                      {7'h0, k[2] | (k[3] ? !k[0] : k[1])});
                check("route", {7'h0, route}, {7'h0, k[3] & k[0]});
            end
        end
    endtask
    task automatic t_refuse();
        host.mem({WIN ^ 4'h1, 16'h0000}, 1'b0, 1'b0);
        check("sel", sel_n, 8'hff);
        host.aen = 1'b1;
        host.mem({WIN, 16'h0000}, 1'b0, 1'b0);
        check("hit", {7'h0, hit}, 8'h00);
        host.aen = 1'b0;
        host.activate(BASE + 20'h6, 1'b1);
        host.mem({WIN, 16'h0002}, 1'b0, 1'b0);
        check("act", {7'h0, act_n}, 8'h01);
        check("strobe", {6'h0, wrl_n, wrh_n}, 8'h03);
        host.activate(BASE + 20'h6, 1'b0);
        host.mem({WIN, 16'h0002}, 1'b1, 1'b1);
        check("hit", {7'h0, hit}, 8'h01);
    endtask
    task automatic t_reset_mid();
        reset_n = 1'b0;
        jmp_n = 1'b1;
        #1 check("page", page, 8'h00);
        host.cyc(2);
        reset_n = 1'b1;
        host.cyc(6);
        check("act", {7'h0, act_n}, 8'h01);
        host.mem({WIN, 16'h0004}, 1'b0, 1'b0);
        check("hit", {7'h0, hit}, 8'h00);
    endtask
    initial begin
        t_reset();
        t_page();
        t_ports();
        t_mem();
        t_refuse();
        t_reset_mid();
        end_sim();
    end
endmodule // paged_flash_board_control_tb
`default_nettype wire
